// [rtl/irq_agg_regs.vh]
// Register offsets, field positions and reset values of the receive interrupt aggregator.
`ifndef IRQ_AGG_REGS_VH
`define IRQ_AGG_REGS_VH

// ----------------------------------------------------------------
// Register offsets
// ----------------------------------------------------------------
`define ADDR_GLOBAL_CONTROL    8'h23
`define ADDR_GLOBAL_STATUS     8'h24
`define ADDR_PORT_SELECT       8'h4c
`define ADDR_STATUS_FIRST      8'h4d
`define ADDR_STATUS_SECOND     8'h4e
`define ADDR_IRQ_ENABLE_HIGH   8'hd8
`define ADDR_IRQ_ENABLE_LOW    8'hd9
`define ADDR_IRQ_STATUS_HIGH   8'hda
`define ADDR_IRQ_STATUS_LOW    8'hdb

// ----------------------------------------------------------------
// Global control and status fields
// ----------------------------------------------------------------
`define BIT_GLOBAL             7
`define BIT_PORT1              1
`define BIT_PORT0              0
`define MASK_GLOBAL_CONTROL    8'h83

// ----------------------------------------------------------------
// Port select fields
// ----------------------------------------------------------------
`define BIT_WRITE_PORT0        0
`define BIT_WRITE_PORT1        1
`define BIT_READ_PORT          4

// ----------------------------------------------------------------
// First receive status fields
// ----------------------------------------------------------------
`define FIELD_FIRST_PORT       7:6
`define BIT_FIRST_CRC          5
`define BIT_FIRST_LOCK_CHG     4
`define BIT_FIRST_SEQ          3
`define BIT_FIRST_PARITY       2
`define BIT_FIRST_PASS         1
`define BIT_FIRST_LOCK         0

// ----------------------------------------------------------------
// Second receive status fields
// ----------------------------------------------------------------
`define BIT_SECOND_ENC         5
`define BIT_SECOND_SETTLED     2
`define BIT_SECOND_NO_CLK      1

// ----------------------------------------------------------------
// Port interrupt status and enable fields (low: parity/pass/lock, high: enc/seq/crc)
// ----------------------------------------------------------------
`define BIT_LOW_PARITY         2
`define BIT_LOW_PASS           1
`define BIT_LOW_LOCK           0
`define BIT_HIGH_ENC           2
`define BIT_HIGH_SEQ           1
`define BIT_HIGH_CRC           0

// ----------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------
`define RST_BYTE               8'h00
`define RST_PORT_SELECT        8'h01

`endif

// [rtl/port_event_latch.v]
// Latched-high event bits of one receive port, with clear on status read.
`include "irq_agg_regs.vh"

module port_event_latch (
    // Clock and reset
    input  wire       sys_clk,
    input  wire       srst,
    // Event pulses from the link
    input  wire       lock_change_evt,
    input  wire       parity_evt,
    input  wire       pass_evt,
    input  wire       encode_evt,
    input  wire       order_evt,
    input  wire       checksum_evt,
    // Clears from status reads
    input  wire       clear_first,
    input  wire       clear_second,
    // Latched flags
    output reg  [2:0] low_flags_q,
    output reg  [2:0] high_flags_q,
    output reg        lock_change_q
);

    wire [2:0] low_set;
    wire [2:0] high_set;

    assign low_set  = {parity_evt, pass_evt, lock_change_evt};
    assign high_set = {encode_evt, order_evt, checksum_evt};

    // ----------------------------------------------------------------
    // Event latches
    // ----------------------------------------------------------------
    // Set has priority over the read clear, so an event in the read cycle survives.
    // Parity, pass, lock, sequence and CRC clear on the first register; encode error on the second.
    always @(posedge sys_clk) begin
        if (srst) begin
            low_flags_q   <= 3'h0;
            high_flags_q  <= 3'h0;
            lock_change_q <= 1'b0;
        end else begin
            low_flags_q   <= low_set | (low_flags_q & {3{~clear_first}});  // RULE18
            high_flags_q[`BIT_HIGH_ENC] <= encode_evt |
                (high_flags_q[`BIT_HIGH_ENC] & ~clear_second);  // RULE8
            high_flags_q[`BIT_HIGH_SEQ] <= order_evt | (high_flags_q[`BIT_HIGH_SEQ] & ~clear_first);
            high_flags_q[`BIT_HIGH_CRC] <= checksum_evt | (high_flags_q[`BIT_HIGH_CRC] & ~clear_first);
            lock_change_q <= lock_change_evt | (lock_change_q & ~clear_first);  // RULE1
        end
    end

endmodule

// [rtl/port_irq_mask.v]
// Per-port enable mask that reduces the latched flags to one pending line.
module port_irq_mask (
    // Latched flags and masks
    input  wire [2:0] low_flags,
    input  wire [2:0] high_flags,
    input  wire [7:0] enable_low,
    input  wire [7:0] enable_high,
    // Result
    output wire       port_pending
);

    // Enables only gate the summary; flags themselves are never masked.
    assign port_pending = |(low_flags & enable_low[2:0]) | |(high_flags & enable_high[2:0]);  // RULE6

endmodule

// [rtl/rx_irq_aggregator.v]
// Top of the two-port receive interrupt aggregator with its register file.
// Contract
// RULE1: Status bits set on their event regardless of enable bits.
// RULE2: Pin asserts only when source enable and global enable are both set.
// RULE3: Port pending shows in global status even with global enable clear.
// RULE4: Interrupt pin is active low.
// RULE5: Pending conditions clear only by reading the source's status register.
// RULE6: Each port has high and low interrupt enable mask registers.
// RULE7: Each port has read-only interrupt status registers mirroring main status bits.
// RULE8: Reading first and second receive status registers clears port conditions.
// RULE9: Global status: bit7 global pending, bit1 port1, bit0 port0.
// RULE10: Global control: bit7 global enable, bit1 port1, bit0 port0.
// RULE11: Low port status: parity bit2, link pass bit1, lock bit0.
// RULE12: High port status: encode bit2, sequence bit1, CRC bit0.
// RULE13: First status: port number, CRC, lock change, seq, parity, pass, lock.
// RULE14: Second status: encode error bit5, settled bit2, clock missing bit1.
// RULE15: Host enables port mask, then port enable, then global enable.
// RULE16: Host must read receive status registers to clear an interrupt.
// RULE17: Paged registers reached through port select for writes and reads.
// RULE18: Latched-high bits hold until their register is read.
// RULE19: Pin stays asserted while any enabled pending condition remains.
`include "irq_agg_regs.vh"

module rx_irq_aggregator #(
    parameter PORTS = 2
) (
    // Clock and reset
    input  wire             sys_clk,
    input  wire             srst,
    // Register access port
    input  wire [7:0]       reg_addr,
    input  wire [7:0]       reg_wdata,
    input  wire             reg_write,
    input  wire             reg_read,
    output reg  [7:0]       reg_rdata,
    // Live link levels per port
    input  wire [PORTS-1:0] link_locked,
    input  wire [PORTS-1:0] link_clock_settled,
    input  wire [PORTS-1:0] link_clock_missing,
    // Link event pulses per port
    input  wire [PORTS-1:0] parity_fault_evt,
    input  wire [PORTS-1:0] quality_ok_evt,
    input  wire [PORTS-1:0] encoding_fault_evt,
    input  wire [PORTS-1:0] order_fault_evt,
    input  wire [PORTS-1:0] checksum_fault_evt,
    // Interrupt pin, open drain
    output wire             irq_out_n,
    output wire             irq_out_oe_n
);

    reg  [7:0]       global_control_q;
    reg  [7:0]       port_select_q;
    reg  [7:0]       enable_high_q [0:PORTS-1];
    reg  [7:0]       enable_low_q  [0:PORTS-1];
    reg  [PORTS-1:0] locked_prev_q;
    wire [2:0]       low_flags   [0:PORTS-1];
    wire [2:0]       high_flags  [0:PORTS-1];
    wire [PORTS-1:0] lock_change;
    wire [PORTS-1:0] port_pending;
    wire [PORTS-1:0] clear_first;
    wire [PORTS-1:0] clear_second;
    wire             read_port;
    wire             any_pending;
    wire             pin_active;
    wire [7:0]       global_status;
    integer          i;

    // ----------------------------------------------------------------
    // Helper functions
    // ----------------------------------------------------------------
    // A port takes a paged write when its write-select bit is set.
    function write_hits;
        input [7:0] sel;
        input integer port;
        begin
            write_hits = (port == 0) ? sel[`BIT_WRITE_PORT0] : sel[`BIT_WRITE_PORT1];
        end
    endfunction

    // Assemble the first receive status byte of a port.
    function [7:0] first_status;
        input       port_num;
        input [2:0] lowf;
        input [2:0] highf;
        input       lock_chg;
        input       locked;
        begin
            first_status = 8'h00;
            first_status[`FIELD_FIRST_PORT] = {1'b0, port_num};  // RULE13
            first_status[`BIT_FIRST_CRC]      = highf[`BIT_HIGH_CRC];
            first_status[`BIT_FIRST_LOCK_CHG] = lock_chg;
            first_status[`BIT_FIRST_SEQ]      = highf[`BIT_HIGH_SEQ];
            first_status[`BIT_FIRST_PARITY]   = lowf[`BIT_LOW_PARITY];
            first_status[`BIT_FIRST_PASS]     = lowf[`BIT_LOW_PASS];
            first_status[`BIT_FIRST_LOCK]     = locked;
        end
    endfunction

    assign read_port = port_select_q[`BIT_READ_PORT];  // RULE17

    // ----------------------------------------------------------------
    // Per-port event latches and masks
    // ----------------------------------------------------------------
    genvar g;
    generate
        for (g = 0; g < PORTS; g = g + 1) begin : gen_port
            // Reads clear only the port that the read selector points at.
            assign clear_first[g]  = reg_read && (reg_addr == `ADDR_STATUS_FIRST) && (read_port == g);  // RULE5
            assign clear_second[g] = reg_read && (reg_addr == `ADDR_STATUS_SECOND) && (read_port == g);  // RULE8

            port_event_latch u_latch (
                .sys_clk         (sys_clk),
                .srst            (srst),
                .lock_change_evt (link_locked[g] ^ locked_prev_q[g]),
                .parity_evt      (parity_fault_evt[g]),
                .pass_evt        (quality_ok_evt[g]),
                .encode_evt      (encoding_fault_evt[g]),
                .order_evt       (order_fault_evt[g]),
                .checksum_evt    (checksum_fault_evt[g]),
                .clear_first     (clear_first[g]),
                .clear_second    (clear_second[g]),
                .low_flags_q     (low_flags[g]),
                .high_flags_q    (high_flags[g]),
                .lock_change_q   (lock_change[g])
            );

            port_irq_mask u_mask (
                .low_flags    (low_flags[g]),
                .high_flags   (high_flags[g]),
                .enable_low   (enable_low_q[g]),
                .enable_high  (enable_high_q[g]),
                .port_pending (port_pending[g])
            );
        end
    endgenerate

    // ----------------------------------------------------------------
    // Global combine and pin
    // ----------------------------------------------------------------
    // Port pending shows in status whenever that port is enabled, even without the global enable.
    assign any_pending = (port_pending[0] & global_control_q[`BIT_PORT0]) |
                         (port_pending[1] & global_control_q[`BIT_PORT1]);  // RULE3
    assign global_status = {any_pending, 5'h00, port_pending[1] & global_control_q[`BIT_PORT1],
                            port_pending[0] & global_control_q[`BIT_PORT0]};  // RULE9
    assign pin_active = any_pending & global_control_q[`BIT_GLOBAL];  // RULE2 RULE19
    // Open drain: the pin is only ever pulled low, never driven high.
    assign irq_out_n    = 1'b0;  // RULE4
    assign irq_out_oe_n = ~pin_active;  // RULE4

    // ----------------------------------------------------------------
    // Register writes
    // ----------------------------------------------------------------
    // A paged write can reach both ports at once when both select bits are set.
    always @(posedge sys_clk) begin
        if (srst) begin
            global_control_q <= `RST_BYTE;
            port_select_q    <= `RST_PORT_SELECT;
            locked_prev_q    <= link_locked;  // A lock held steady across reset is not a change.
            for (i = 0; i < PORTS; i = i + 1) begin
                enable_high_q[i] <= `RST_BYTE;
                enable_low_q[i]  <= `RST_BYTE;
            end
        end else begin
            locked_prev_q <= link_locked;
            if (reg_write && reg_addr == `ADDR_GLOBAL_CONTROL) begin
                global_control_q <= reg_wdata & `MASK_GLOBAL_CONTROL;  // RULE10
            end
            if (reg_write && reg_addr == `ADDR_PORT_SELECT) begin
                port_select_q <= reg_wdata;  // RULE17
            end
            for (i = 0; i < PORTS; i = i + 1) begin
                if (reg_write && write_hits(port_select_q, i)) begin
                    if (reg_addr == `ADDR_IRQ_ENABLE_HIGH) begin
                        enable_high_q[i] <= reg_wdata;  // RULE6
                    end
                    if (reg_addr == `ADDR_IRQ_ENABLE_LOW) begin
                        enable_low_q[i] <= reg_wdata;  // RULE6
                    end
                end
            end
        end
    end

    // ----------------------------------------------------------------
    // Register reads
    // ----------------------------------------------------------------
    // Read data is registered; it reflects flag values before the same read's clear.
    always @(posedge sys_clk) begin
        if (srst) begin
            reg_rdata <= `RST_BYTE;
        end else if (reg_read) begin
            case (reg_addr)
                `ADDR_GLOBAL_CONTROL:  reg_rdata <= global_control_q;
                `ADDR_GLOBAL_STATUS:   reg_rdata <= global_status;  // RULE9
                `ADDR_PORT_SELECT:     reg_rdata <= port_select_q;
                `ADDR_STATUS_FIRST:    reg_rdata <= first_status(read_port, low_flags[read_port],
                                            high_flags[read_port], lock_change[read_port],
                                            link_locked[read_port]);  // RULE13
                `ADDR_STATUS_SECOND:   reg_rdata <= {2'b00, high_flags[read_port][`BIT_HIGH_ENC], 2'b00,
                                            link_clock_settled[read_port],
                                            link_clock_missing[read_port], 1'b0};  // RULE14
                `ADDR_IRQ_ENABLE_HIGH: reg_rdata <= enable_high_q[read_port];
                `ADDR_IRQ_ENABLE_LOW:  reg_rdata <= enable_low_q[read_port];
                `ADDR_IRQ_STATUS_HIGH: reg_rdata <= {5'h00, high_flags[read_port]};  // RULE7 RULE12
                `ADDR_IRQ_STATUS_LOW:  reg_rdata <= {5'h00, low_flags[read_port]};  // RULE7 RULE11
                default:               reg_rdata <= `RST_BYTE;
            endcase
        end
    end

endmodule

// [tb/host_model.sv]
// Host model: register access strobes and the pulled-up interrupt line.
module host_model (
    // Clock
    input  wire logic       sys_clk,
    // Register access
    output var  logic [7:0] reg_addr,
    output var  logic [7:0] reg_wdata,
    output var  logic       reg_write,
    output var  logic       reg_read,
    input  wire logic [7:0] reg_rdata,
    // Interrupt pin
    input  wire logic       irq_out_n,
    input  wire logic       irq_out_oe_n,
    output wire logic       irq_line
);
    timeunit 1ns;
    timeprecision 1ps;
    // ----------------------------------------
    // Line and access tasks
    // ----------------------------------------
    // Pull-up: a released pin reads high, never a stale driven value.
    assign irq_line = irq_out_oe_n ? 1'b1 : irq_out_n;

    initial begin
        reg_addr = 8'h00;
        reg_wdata = 8'h00;
        reg_write = 1'b0;
        reg_read = 1'b0;
    end

    // Each access leaves a gap cycle, so a strobe is never set twice in one step.
    task wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge sys_clk);
        reg_addr <= a;
        reg_wdata <= d;
        reg_write <= 1'b1;
        @(posedge sys_clk);
        reg_write <= 1'b0;
        #1;
    endtask

    // Read data lands at the sampling edge; take it once that edge has settled.
    task rd(input logic [7:0] a, output logic [7:0] d);
        @(posedge sys_clk);
        reg_addr <= a;
        reg_read <= 1'b1;
        @(posedge sys_clk);
        reg_read <= 1'b0;
        #1;
        d = reg_rdata;
    endtask
endmodule

// [tb/rx_irq_checker_sva.sv]
// Port-level assertions for the receive interrupt aggregator.
module rx_irq_checker #(
    parameter PORTS = 2
) (
    // Clock and reset
    input wire logic       sys_clk,
    input wire logic       srst,
    // Register access
    input wire logic [7:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    input wire logic       reg_write,
    input wire logic       reg_read,
    input wire logic [7:0] reg_rdata,
    // Interrupt pin
    input wire logic       irq_out_n,
    input wire logic       irq_out_oe_n
);
    timeunit 1ns;
    timeprecision 1ps;
    // ----------------------------------------
    // Shadow state and checks
    // ----------------------------------------
    logic [7:0] ctl_q;

    default clocking cb @(posedge sys_clk);
    endclocking
    default disable iff (srst);

    // Shadow of the global control byte, so the pin can be judged against its enable.
    always @(posedge sys_clk) begin
        if (srst) begin
            ctl_q <= 8'h00;
        end else if (reg_write && reg_addr == 8'h23) begin
            ctl_q <= reg_wdata & 8'h83;
        end
    end

    AST_PIN_DATA_LOW: assert property (irq_out_n == 1'b0)
        else $error("pin data level is not low");
    AST_RESET_IDLE: assert property ($fell(srst) |-> irq_out_oe_n && reg_rdata == 8'h00)
        else $error("pin or read data not idle after reset");
    AST_NO_PIN_WITHOUT_GLOBAL: assert property (!ctl_q[7] |-> irq_out_oe_n)
        else $error("pin driven with global enable clear");
    AST_RDATA_HOLDS: assert property (!reg_read |=> $stable(reg_rdata))
        else $error("read data changed without a read");
    AST_STATUS_LAYOUT: assert property (reg_read && reg_addr == 8'h24 |=>
        reg_rdata == {|reg_rdata[1:0], 5'h00, reg_rdata[1:0]}) else $error("global status layout wrong");
    AST_STATUS_VS_PIN: assert property (reg_read && reg_addr == 8'h24 && ctl_q[7] |=>
        reg_rdata[7] == !$past(irq_out_oe_n)) else $error("global pending and pin disagree");
    AST_CONTROL_READBACK: assert property (reg_read && reg_addr == 8'h23 |=>
        reg_rdata == $past(ctl_q)) else $error("global control readback wrong");
    AST_RELEASE_BY_ACCESS: assert property ($rose(irq_out_oe_n) |->
        $past(reg_read) || $past(reg_write)) else $error("pin released without an access");
    AST_UNMAPPED_ZERO: assert property (reg_read && reg_addr < 8'h23 |=> reg_rdata == 8'h00)
        else $error("unmapped read not zero");
endmodule

// [tb/testbench.sv]
// Self-checking bench for the receive interrupt aggregator.
module testbench;
    timeunit 1ns;
    timeprecision 1ps;
    // ----------------------------------------
    // Design, host and helpers
    // ----------------------------------------
    logic       sys_clk = 1'b0;
    logic       srst = 1'b1;
    logic [1:0] lock_q = 2'b00;
    logic [1:0] settled_q = 2'b00;
    logic [1:0] missing_q = 2'b00;
    logic [9:0] evs = 10'h000;
    wire  [7:0] reg_addr, reg_wdata, reg_rdata;
    wire        reg_write, reg_read, irq_out_n, irq_out_oe_n, irq_line;
    int         errors = 0;
    int         n_checks = 0;

    always #5 sys_clk = ~sys_clk;

    host_model host (.sys_clk(sys_clk), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_write(reg_write),
        .reg_read(reg_read), .reg_rdata(reg_rdata), .irq_out_n(irq_out_n), .irq_out_oe_n(irq_out_oe_n),
        .irq_line(irq_line));
    // Event pulses are packed two bits per kind: parity, pass, encode, order, checksum.
    rx_irq_aggregator #(.PORTS(2)) DUT (.sys_clk(sys_clk), .srst(srst), .reg_addr(reg_addr),
        .reg_wdata(reg_wdata), .reg_write(reg_write), .reg_read(reg_read), .reg_rdata(reg_rdata),
        .link_locked(lock_q), .link_clock_settled(settled_q), .link_clock_missing(missing_q),
        .parity_fault_evt(evs[1:0]), .quality_ok_evt(evs[3:2]), .encoding_fault_evt(evs[5:4]),
        .order_fault_evt(evs[7:6]), .checksum_fault_evt(evs[9:8]), .irq_out_n(irq_out_n),
        .irq_out_oe_n(irq_out_oe_n));

    task chk(input string n, input logic [7:0] e, input logic [7:0] g);
        n_checks++;
        if (g !== e) begin
            errors++;
            $display("[FAIL] %s expected %h seen %h", n, e, g);
        end
    endtask

    task rdc(input logic [7:0] a, input logic [7:0] e);
        logic [7:0] d;
        host.rd(a, d);
        chk($sformatf("register %h", a), e, d);
    endtask

    task pin(input logic e);
        chk("pin level", {7'h00, e}, {7'h00, irq_line});
    endtask

    task pulse(input logic [9:0] m);
        @(posedge sys_clk);
        evs <= m;
        @(posedge sys_clk);
        evs <= 10'h000;
        #1;
    endtask

    task conclude();
        $display("checks %0d mismatches %0d", n_checks, errors);
        if (errors == 0 && n_checks > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask

    // ----------------------------------------
    // Tests
    // ----------------------------------------
    // A hang is cut short here and reported as a mismatch.
    initial begin
        repeat (3000) @(posedge sys_clk);
        errors++;
        $display("[FAIL] run length expected done seen timeout");
        conclude();
    end

    initial begin
        repeat (12) @(posedge sys_clk);
        srst <= 1'b0;
        rdc(8'h23, 8'h00);
        rdc(8'h4c, 8'h01);
        pin(1'b1);
        $display("test reset done");
        // A masked event still latches but stays off the pin.
        pulse(10'h001);
        rdc(8'hdb, 8'h04);
        rdc(8'h24, 8'h00);
        host.wr(8'hd9, 8'h04);
        rdc(8'hd9, 8'h04);
        host.wr(8'h23, 8'h01);
        rdc(8'h24, 8'h81);
        pin(1'b1);
        host.wr(8'h23, 8'h81);
        pin(1'b0);
        rdc(8'h24, 8'h81);
        rdc(8'hdb, 8'h04);
        rdc(8'h4e, 8'h00);
        pin(1'b0);
        rdc(8'h4d, 8'h04);
        pin(1'b1);
        rdc(8'hdb, 8'h00);
        $display("test port0 done");
        // Port 1 faults need both status reads before the pin lets go.
        @(posedge sys_clk);
        settled_q <= 2'b10;
        missing_q <= 2'b10;
        host.wr(8'h4c, 8'h12);
        host.wr(8'hd8, 8'h07);
        host.wr(8'h23, 8'h82);
        pulse(10'h2a0);
        pin(1'b0);
        rdc(8'hda, 8'h07);
        rdc(8'h24, 8'h82);
        rdc(8'h4d, 8'h68);
        pin(1'b0);
        rdc(8'hda, 8'h04);
        rdc(8'h4e, 8'h26);
        pin(1'b1);
        $display("test port1 done");
        // Lock change and link pass latch until the first status read.
        host.wr(8'h4c, 8'h01);
        rdc(8'hd9, 8'h04);
        @(posedge sys_clk);
        lock_q <= 2'b01;
        pulse(10'h004);
        rdc(8'hdb, 8'h03);
        rdc(8'h4d, 8'h13);
        rdc(8'h4d, 8'h01);
        // A paged write with both select bits reaches both ports; with none it reaches neither.
        host.wr(8'h4c, 8'h03);
        host.wr(8'hd8, 8'h05);
        rdc(8'hd8, 8'h05);
        host.wr(8'h4c, 8'h10);
        host.wr(8'hd9, 8'hff);
        rdc(8'hd8, 8'h05);
        rdc(8'hd9, 8'h00);
        // An event in the cycle of the clearing read wins, so the flag survives that read.
        fork
            rdc(8'h4d, 8'h40);
            pulse(10'h002);
        join
        rdc(8'hdb, 8'h04);
        rdc(8'h4d, 8'h44);
        rdc(8'hdb, 8'h00);
        // Writes to read-only and unused bits are refused.
        host.wr(8'h24, 8'hff);
        rdc(8'h24, 8'h00);
        host.wr(8'h23, 8'hff);
        rdc(8'h23, 8'h83);
        rdc(8'h10, 8'h00);
        @(posedge sys_clk);
        srst <= 1'b1;
        repeat (2) @(posedge sys_clk);
        srst <= 1'b0;
        rdc(8'h23, 8'h00);
        rdc(8'hdb, 8'h00);
        $display("test refusal and reset done");
        conclude();
    end
endmodule

bind rx_irq_aggregator rx_irq_checker #(.PORTS(PORTS)) chk_i (.sys_clk(sys_clk), .srst(srst),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_write(reg_write), .reg_read(reg_read),
    .reg_rdata(reg_rdata), .irq_out_n(irq_out_n), .irq_out_oe_n(irq_out_oe_n));
